// [mrae_pkg.sv]
package mrae_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_CHMASK   = 12'h004;
    localparam logic [11:0] OFS_RECLEN   = 12'h008;
    localparam logic [11:0] OFS_PRETRIG  = 12'h00C;
    localparam logic [11:0] OFS_STATUS   = 12'h010;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h014;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h018;
    localparam logic [11:0] OFS_AVAIL    = 12'h01C;
    localparam logic [11:0] OFS_WRAP     = 12'h020;
    localparam logic [11:0] OFS_FETCH    = 12'h024;
    localparam logic [11:0] OFS_RECNUM   = 12'h028;
    // control bit positions
    localparam int CTRL_ARM_BIT  = 0;
    localparam int CTRL_RAW_BIT  = 1;
    localparam int CTRL_DISARM_BIT = 2;
    // interrupt bit positions
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_LOST_BIT = 1;
    localparam int IRQ_RDY_BIT  = 2;
    // reset values
    localparam logic [7:0]  CHMASK_RST  = 8'hFF;
    localparam logic [31:0] RECLEN_RST  = 32'h0000_0400;
    localparam logic [31:0] PRETRIG_RST = 32'h0000_0100;
    // memory size and header size
    localparam longint MEM_BYTES    = 64'h4000_0000;
    localparam int     HDR_BYTES    = 40;
    localparam int     SAMPLE_BYTES = 2;
    localparam logic [31:0] HDR_WORDS = 32'(HDR_BYTES / SAMPLE_BYTES);
    // re-arm time
    localparam int REARM_NS     = 100;
    localparam int CLK_PERIOD_NS = 5;
    localparam int REARM_CYCLES = (REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_PRE   = 3'b001,
        ST_POST  = 3'b011,
        ST_HDR   = 3'b010,
        ST_REARM = 3'b110
    } mrae_state_t;

    // memory write beat
    typedef struct packed {
        logic        valid;
        logic        is_hdr;
        logic [29:0] addr;
        logic [15:0] data;
    } mrae_mem_wr_t;

    // whole module state
    typedef struct packed {
        mrae_state_t  st;
        logic         armed;
        logic         raw;
        logic [7:0]   chmask;
        logic [31:0]  reclen;
        logic [31:0]  pretrig;
        logic [29:0]  base;
        logic [31:0]  pos;
        logic [31:0]  fill;
        logic [31:0]  post_cnt;
        logic [31:0]  wrap_pos;
        logic [31:0]  last_wrap;
        logic [63:0]  ts;
        logic [63:0]  trig_ts;
        logic [2:0]   trig_ch;
        logic [4:0]   hdr_idx;
        logic         lost;
        logic [31:0]  recnum;
        logic [31:0]  avail;
        logic [2:0]   irq_stat;
        logic [2:0]   irq_mask;
        logic [15:0]  rearm_cnt;
        logic [29:0]  used;
        logic         fetch;
        logic [31:0]  prdata;
        logic         pready;
        logic         irq;
        mrae_mem_wr_t mw;
    } mrae_regs_t;
endpackage : mrae_pkg

// [mrae_engine.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// - one 1 GByte acquisition memory space
// - memory shared by all enabled channels
// - channel mask drops unselected channel samples
// - header with timestamp and channel per record
// - normal mode headers, raw mode none
// - header space taken from same memory
// - memory is FIFO, write and read overlap
// - one circular buffer per record
// - armed wait overwrites oldest samples circularly
// - after trigger write length minus pretrigger
// - expose wrap position for host unwrapping
// - readout only on host request after completion
// - fixed re-arm period ignores triggers, samples
// - each header exactly 40 bytes
// - FIFO overflow drops data, flags lost
module mrae_engine #(
    parameter int NCH       = 8,    // channel count
    parameter int ADDR_W    = 30    // memory word address width
) (
    input  wire logic        sys_clk,     // 200 MHz clock
    input  wire logic        rst_b,       // async reset, active low
    input  wire logic [11:0] paddr,       // apb address
    input  wire logic        psel,        // apb select
    input  wire logic        penable,     // apb enable
    input  wire logic        pwrite,      // apb direction
    input  wire logic [31:0] pwdata,      // apb write data
    output logic      [31:0] prdata,      // apb read data
    output logic             pready,      // apb ready
    output logic             pslverr,     // apb error
    input  wire logic        smp_valid,   // sample stream valid
    input  wire logic [2:0]  smp_ch,      // sample channel number
    input  wire logic [15:0] smp_data,    // sample value
    input  wire logic        trig,        // trigger pulse
    input  wire logic        mem_ready,   // memory accepts a beat
    input  wire logic        rd_done,     // host read drained one record
    output logic             mem_valid,   // memory write strobe
    output logic             mem_is_hdr,  // beat is header
    output logic      [29:0] mem_addr,    // memory word address
    output logic      [15:0] mem_data,    // memory word
    output logic             fetch_req,   // pulse: host asks readout
    output logic             irq          // level interrupt
);
    mrae_pkg::mrae_regs_t r_r;            // registered state
    mrae_pkg::mrae_regs_t r_nxt;          // next state

    localparam logic [29:0] MEM_WORDS_M1 = 30'h1FFF_FFFF; // 1 GByte of 16-bit words minus one

    // selected-channel test
    function automatic logic ch_sel(input logic [7:0] m, input logic [2:0] c);
        ch_sel = m[c];
    endfunction : ch_sel

    // next circular position within one record buffer
    function automatic logic [31:0] pos_inc(input logic [31:0] p, input logic [31:0] len);
        pos_inc = (p + 32'h1 >= len) ? 32'h0 : p + 32'h1;
    endfunction : pos_inc

    // header words: status, ch, record number, ts, wrap position, length
    function automatic logic [15:0] hdr_word(input mrae_pkg::mrae_regs_t s);
        case (s.hdr_idx)
            5'h00:   hdr_word = {13'h0000, s.lost, 2'h0};
            5'h01:   hdr_word = {13'h0000, s.trig_ch};
            5'h02:   hdr_word = s.recnum[15:0];
            5'h03:   hdr_word = s.recnum[31:16];
            5'h04:   hdr_word = s.trig_ts[15:0];
            5'h05:   hdr_word = s.trig_ts[31:16];
            5'h06:   hdr_word = s.trig_ts[47:32];
            5'h07:   hdr_word = s.trig_ts[63:48];
            5'h08:   hdr_word = s.wrap_pos[15:0];
            5'h09:   hdr_word = s.wrap_pos[31:16];
            5'h0A:   hdr_word = s.reclen[15:0];
            5'h0B:   hdr_word = s.reclen[31:16];
            default: hdr_word = 16'h0000;
        endcase
    endfunction : hdr_word

    logic        wr_acc;    // apb write access phase
    logic        rd_acc;    // apb read setup phase, data ready with pready
    logic        take;      // sample accepted by channel mask
    logic        mem_busy;  // previous beat not yet taken
    logic [29:0] rec_words; // record footprint in memory
    logic        fits;      // room for another record

    // next-state logic
    always_comb begin
        r_nxt     = r_r;
        wr_acc    = psel && penable && pwrite;
        rd_acc    = psel && !penable && !pwrite;
        take      = smp_valid && ch_sel(r_r.chmask, smp_ch);
        mem_busy  = r_r.mw.valid && !mem_ready;
        rec_words = r_r.reclen[29:0] + (r_r.raw ? 30'h0 : mrae_pkg::HDR_WORDS[29:0]);
        fits      = (r_r.used + rec_words) <= MEM_WORDS_M1;
        r_nxt.ts  = r_r.ts + 64'h1;
        r_nxt.fetch  = 1'b0;
        r_nxt.pready = 1'b0;
        // retire accepted beat
        if (r_r.mw.valid && mem_ready) begin
            r_nxt.mw.valid = 1'b0;
        end
        // drained record frees fifo space
        if (rd_done && r_r.used >= rec_words) begin
            r_nxt.used = r_r.used - rec_words;
        end
        // apb register writes
        if (psel && !penable) begin
            r_nxt.pready = 1'b1;
        end
        if (wr_acc && r_r.pready) begin
            case (paddr)
                mrae_pkg::OFS_CTRL: begin
                    if (pwdata[mrae_pkg::CTRL_ARM_BIT]) begin
                        r_nxt.armed = 1'b1;
                    end
                    if (pwdata[mrae_pkg::CTRL_DISARM_BIT]) begin
                        r_nxt.armed = 1'b0;
                    end
                    r_nxt.raw = pwdata[mrae_pkg::CTRL_RAW_BIT];
                end
                mrae_pkg::OFS_CHMASK:   r_nxt.chmask   = pwdata[7:0];
                mrae_pkg::OFS_RECLEN:   r_nxt.reclen   = pwdata;
                mrae_pkg::OFS_PRETRIG:  r_nxt.pretrig  = pwdata;
                mrae_pkg::OFS_IRQ_STAT: r_nxt.irq_stat = r_r.irq_stat & ~pwdata[2:0];
                mrae_pkg::OFS_IRQ_MASK: r_nxt.irq_mask = pwdata[2:0];
                mrae_pkg::OFS_FETCH: begin
                    // readout only for a completed record
                    if (pwdata[0] && r_r.avail != 32'h0) begin
                        r_nxt.fetch = 1'b1;
                        r_nxt.avail = r_r.avail - 32'h1;
                    end
                end
                default: begin
                end
            endcase
        end
        // acquisition sequencer
        case (r_r.st)
            mrae_pkg::ST_IDLE: begin
                // wait for arm and room in memory
                if (r_r.armed && fits && r_r.reclen != 32'h0) begin
                    r_nxt.st        = mrae_pkg::ST_PRE;
                    r_nxt.pos       = 32'h0;
                    r_nxt.fill      = 32'h0;
                    r_nxt.lost      = 1'b0;
                    r_nxt.used      = r_nxt.used + rec_words;
                end
            end
            mrae_pkg::ST_PRE: begin
                // circular fill, trigger ends the pre part
                if (trig && r_r.fill >= r_r.pretrig) begin
                    r_nxt.st       = mrae_pkg::ST_POST;
                    r_nxt.trig_ts  = r_r.ts;
                    r_nxt.trig_ch  = smp_ch;
                    r_nxt.post_cnt = r_r.reclen - r_r.pretrig;
                    r_nxt.wrap_pos = r_r.pos;
                end else if (take) begin
                    if (mem_busy) begin
                        r_nxt.lost = 1'b1;
                    end else begin
                        r_nxt.mw   = '{1'b1, 1'b0, r_r.base + r_r.pos[29:0], smp_data};
                        r_nxt.pos  = pos_inc(r_r.pos, r_r.reclen);
                        r_nxt.fill = (r_r.fill < r_r.reclen) ? r_r.fill + 32'h1 : r_r.fill;
                    end
                end
            end
            mrae_pkg::ST_POST: begin
                // write the post-trigger samples
                if (r_r.post_cnt == 32'h0) begin
                    r_nxt.st      = r_r.raw ? mrae_pkg::ST_REARM : mrae_pkg::ST_HDR;
                    r_nxt.hdr_idx = 5'h00;
                    r_nxt.rearm_cnt = 16'(mrae_pkg::REARM_CYCLES);
                    if (r_r.raw) begin
                        r_nxt.avail     = r_nxt.avail + 32'h1;
                        r_nxt.last_wrap = r_r.wrap_pos;
                        r_nxt.recnum    = r_r.recnum + 32'h1;
                        r_nxt.irq_stat[mrae_pkg::IRQ_DONE_BIT] = 1'b1;
                    end
                end else if (take) begin
                    if (mem_busy) begin
                        r_nxt.lost = 1'b1;
                    end else begin
                        r_nxt.mw       = '{1'b1, 1'b0, r_r.base + r_r.pos[29:0], smp_data};
                        r_nxt.pos      = pos_inc(r_r.pos, r_r.reclen);
                        r_nxt.post_cnt = r_r.post_cnt - 32'h1;
                    end
                end
            end
            mrae_pkg::ST_HDR: begin
                // emit 40-byte header after the data area
                if (!mem_busy) begin
                    r_nxt.mw = '{1'b1, 1'b1, r_r.base + r_r.reclen[29:0]
                                 + 30'(r_r.hdr_idx), hdr_word(r_r)};
                    r_nxt.hdr_idx = r_r.hdr_idx + 5'h01;
                    if (32'(r_r.hdr_idx) == mrae_pkg::HDR_WORDS - 32'h1) begin
                        r_nxt.st        = mrae_pkg::ST_REARM;
                        r_nxt.avail     = r_nxt.avail + 32'h1;
                        r_nxt.last_wrap = r_r.wrap_pos;
                        r_nxt.recnum    = r_r.recnum + 32'h1;
                        r_nxt.irq_stat[mrae_pkg::IRQ_DONE_BIT] = 1'b1;
                    end
                end
            end
            mrae_pkg::ST_REARM: begin
                // fixed dead time, triggers and samples ignored
                r_nxt.rearm_cnt = r_r.rearm_cnt - 16'h1;
                if (r_r.rearm_cnt == 16'h1) begin
                    r_nxt.st   = mrae_pkg::ST_IDLE;
                    r_nxt.base = (r_r.base + rec_words > MEM_WORDS_M1 - rec_words)
                                 ? 30'h0 : r_r.base + rec_words;
                    r_nxt.irq_stat[mrae_pkg::IRQ_RDY_BIT] = 1'b1;
                end
            end
            default: r_nxt.st = mrae_pkg::ST_IDLE;
        endcase
        // lost data flag event
        if (r_nxt.lost && !r_r.lost) begin
            r_nxt.irq_stat[mrae_pkg::IRQ_LOST_BIT] = 1'b1;
        end
        // apb read mux, loaded at setup so prdata stands with pready
        if (rd_acc) begin
            case (paddr)
                mrae_pkg::OFS_CTRL:     r_nxt.prdata = {30'h0, r_r.raw, r_r.armed};
                mrae_pkg::OFS_CHMASK:   r_nxt.prdata = {24'h0, r_r.chmask};
                mrae_pkg::OFS_RECLEN:   r_nxt.prdata = r_r.reclen;
                mrae_pkg::OFS_PRETRIG:  r_nxt.prdata = r_r.pretrig;
                mrae_pkg::OFS_STATUS:   r_nxt.prdata = {28'h0, r_r.lost, r_r.st};
                mrae_pkg::OFS_IRQ_STAT: r_nxt.prdata = {29'h0, r_r.irq_stat};
                mrae_pkg::OFS_IRQ_MASK: r_nxt.prdata = {29'h0, r_r.irq_mask};
                mrae_pkg::OFS_AVAIL:    r_nxt.prdata = r_r.avail;
                mrae_pkg::OFS_WRAP:     r_nxt.prdata = r_r.last_wrap;
                mrae_pkg::OFS_RECNUM:   r_nxt.prdata = r_r.recnum;
                default:                r_nxt.prdata = 32'h0000_0000;
            endcase
        end
        r_nxt.irq = |(r_nxt.irq_stat & r_nxt.irq_mask);
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            r_r         <= '0;
            r_r.st      <= mrae_pkg::ST_IDLE;
            r_r.chmask  <= mrae_pkg::CHMASK_RST;
            r_r.reclen  <= mrae_pkg::RECLEN_RST;
            r_r.pretrig <= mrae_pkg::PRETRIG_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // outputs straight from state flops, pslverr tied low
    assign prdata     = r_r.prdata;
    assign pready     = r_r.pready;
    assign pslverr    = 1'b0;
    assign mem_valid  = r_r.mw.valid;
    assign mem_is_hdr = r_r.mw.is_hdr;
    assign mem_addr   = r_r.mw.addr;
    assign mem_data   = r_r.mw.data;
    assign fetch_req  = r_r.fetch;
    assign irq        = r_r.irq;
endmodule : mrae_engine
`default_nettype wire

// [mrae_engine_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// watches the engine ports for bus, memory beat and record framing
module mrae_engine_chk (
    input wire logic        sys_clk,    // clock
    input wire logic        rst_b,      // reset, active low
    input wire logic [11:0] paddr,      // apb address
    input wire logic        psel,       // apb select
    input wire logic        penable,    // apb enable
    input wire logic        pwrite,     // apb direction
    input wire logic        pready,     // apb ready
    input wire logic        pslverr,    // apb error
    input wire logic        mem_valid,  // memory write strobe
    input wire logic        mem_ready,  // memory accepts
    input wire logic        mem_is_hdr, // header beat
    input wire logic [29:0] mem_addr,   // word address
    input wire logic [15:0] mem_data,   // word
    input wire logic        fetch_req   // readout pulse
);
    int   hcnt_r;  // accepted header words of the current record
    logic hdr_end; // last header word accepted
    assign hdr_end = mem_valid && mem_ready && mem_is_hdr && hcnt_r == 19;
    // count header words, wrap after a whole header
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) hcnt_r <= 0;
        else if (mem_valid && mem_ready && mem_is_hdr) hcnt_r <= hdr_end ? 0 : hcnt_r + 1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    AST_APB_RDY: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_APB_PHASE: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside access phase");
    AST_NO_ERR: assert property (!pslverr)
        else $error("slave error raised");
    AST_MEM_HOLD: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr)
        && $stable(mem_data) && $stable(mem_is_hdr)) else $error("beat changed while stalled");
    AST_FETCH_PULSE: assert property (fetch_req |=> !fetch_req)
        else $error("fetch longer than a cycle");
    AST_FETCH_CAUSE: assert property (fetch_req |-> $past(psel && penable && pwrite && paddr
        == mrae_pkg::OFS_FETCH) || $past(psel && penable && pwrite && paddr
        == mrae_pkg::OFS_FETCH, 2)) else $error("fetch without host write");
    AST_MEM_RANGE: assert property (mem_valid |-> !mem_addr[29])
        else $error("address beyond memory");
    AST_HDR_WHOLE: assert property (mem_valid && !mem_is_hdr |-> hcnt_r == 0)
        else $error("data inside a header");
    AST_REARM_QUIET: assert property (hdr_end |=> !mem_valid [*8])
        else $error("write during re-arm");
endmodule : mrae_engine_chk
bind mrae_engine mrae_engine_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_is_hdr(mem_is_hdr),
    .mem_addr(mem_addr), .mem_data(mem_data), .fetch_req(fetch_req));
`default_nettype wire

// [mrae_host_mdl.sv]
`timescale 1ns/1ps
`default_nettype none
// host transfer path: sinks memory beats, drains a record only when asked
module mrae_host_mdl (
    input  wire logic sys_clk,   // clock
    input  wire logic rst_b,     // reset, active low
    input  wire logic stall,     // bench asks the memory to stall
    input  wire logic fetch_req, // readout request pulse
    output logic      mem_ready, // memory accepts a beat
    output logic      rd_done,   // one record drained
    output int        fetch_n    // readouts seen
);
    logic [2:0] dly_r; // readout latency pipe
    // memory keeps accepting beats while a readout runs
    assign mem_ready = !stall;
    // drain starts only on a request, finishes four cycles later
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dly_r   <= 3'h0;
            rd_done <= 1'b0;
            fetch_n <= 0;
        end else begin
            dly_r   <= {dly_r[1:0], fetch_req};
            rd_done <= dly_r[2];
            if (fetch_req) fetch_n <= fetch_n + 1;
        end
    end
endmodule : mrae_host_mdl
`default_nettype wire

// [multi_record_acquisition_engine_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module multi_record_acquisition_engine_tb;
    logic sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, smp_valid = 1'b0, trig = 1'b0, stall = 1'b0;
    logic [2:0] smp_ch = 3'h0;
    logic [15:0] smp_data = 16'h0, mem_data, lfsr_r = 16'h002D;
    logic mem_ready, rd_done, mem_valid, mem_is_hdr, fetch_req, irq;
    logic [29:0] mem_addr;
    logic [7:0] mask = 8'hFF;      // model copy of channel selection
    logic [15:0] expq[$];          // samples expected after the trigger
    int mismatches = 0, compares = 0, fetch_n, hdr_n = 0, post_n = 0;
    bit post = 0;                  // record is past its trigger
    logic [31:0] q;
    localparam int RL = 16, PT = 4; // short record, whole run fits memory
    always #2.5 sys_clk = ~sys_clk;
    mrae_engine DUT (.sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .smp_valid(smp_valid), .smp_ch(smp_ch), .smp_data(smp_data),
        .trig(trig), .mem_ready(mem_ready), .rd_done(rd_done), .mem_valid(mem_valid),
        .mem_is_hdr(mem_is_hdr), .mem_addr(mem_addr), .mem_data(mem_data),
        .fetch_req(fetch_req), .irq(irq));
    mrae_host_mdl HOST (.sys_clk(sys_clk), .rst_b(rst_b), .stall(stall), .fetch_req(fetch_req),
        .mem_ready(mem_ready), .rd_done(rd_done), .fetch_n(fetch_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        // wait for ready; only the watchdog ends a hang
        do begin @(posedge sys_clk); end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd_chk
    // next value of the stimulus shift register
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    // send n counted samples; pre ones on channel 0, later ones on random channels
    task automatic smp(input int n, input bit pre, input bit st);
        int k;
        logic [2:0] c;
        k = 0;
        while (k < n) begin
            @(posedge sys_clk);
            lfsr_r = lfsr_next(lfsr_r);
            c = pre ? 3'h0 : lfsr_r[2:0];
            {smp_valid, smp_ch, smp_data, stall} <= {1'b1, c, lfsr_r, st & lfsr_r[5]};
            if (pre || mask[c]) k++;
            if (!pre && mask[c]) expq.push_back(lfsr_r);
        end
        @(posedge sys_clk);
        {smp_valid, stall} <= 2'b00;
    endtask : smp
    // one record: wrapping pre-trigger fill, trigger, post-trigger part
    task automatic rec(input bit st, input logic [31:0] n_avail);
        int n;
        {post, post_n, hdr_n, n} = {1'b0, 32'd0, 32'd0, 32'd0};
        smp(40, 1'b1, st);
        repeat (2) @(posedge sys_clk);
        trig <= 1'b1;
        post = 1;
        @(posedge sys_clk);
        trig <= 1'b0;
        smp(RL - PT, 1'b0, 1'b0);
        do begin apb(1'b0, mrae_pkg::OFS_AVAIL, 32'h0); n++; end while (q !== n_avail && n < 300);
        chk(q, n_avail);
        chk(post_n, RL - PT);
    endtask : rec
    // memory beats: count headers, compare post-trigger data with the model
    always @(posedge sys_clk) begin
        if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
            if (mem_is_hdr) begin
                chk(mem_addr, RL + hdr_n);
                hdr_n++;
            end else if (post) begin
                post_n++;
                chk(mem_data, (expq.size() > 0) ? expq.pop_front() : 16'hXXXX);
            end
        end
    end
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        #400000;
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd_chk(mrae_pkg::OFS_CHMASK, 32'h0000_00FF);
        rd_chk(mrae_pkg::OFS_RECLEN, 32'h0000_0400);
        rd_chk(mrae_pkg::OFS_PRETRIG, 32'h0000_0100);
        rd_chk(12'h030, 32'h0);
        apb(1'b1, mrae_pkg::OFS_FETCH, 32'h1);
        repeat (6) @(posedge sys_clk);
        chk(fetch_n, 0);
        $display("test reset values done");
        mask = 8'h05;
        apb(1'b1, mrae_pkg::OFS_CHMASK, 32'h5);
        apb(1'b1, mrae_pkg::OFS_RECLEN, RL);
        apb(1'b1, mrae_pkg::OFS_PRETRIG, PT);
        apb(1'b1, mrae_pkg::OFS_IRQ_MASK, 32'h1);
        apb(1'b1, mrae_pkg::OFS_CTRL, 32'h1);
        rec(1'b1, 32'h1);
        chk(hdr_n, mrae_pkg::HDR_WORDS);
        apb(1'b0, mrae_pkg::OFS_STATUS, 32'h0);
        chk(q[3], 1'b1);
        apb(1'b0, mrae_pkg::OFS_WRAP, 32'h0);
        chk(q < RL, 1'b1);
        $display("test record with stalls done");
        repeat (30) @(posedge sys_clk);
        chk(irq, 1'b1);
        apb(1'b1, mrae_pkg::OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        apb(1'b1, mrae_pkg::OFS_IRQ_MASK, 32'h7);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b1);
        apb(1'b0, mrae_pkg::OFS_IRQ_STAT, 32'h0);
        chk(q[1:0], 2'b11);
        apb(1'b1, mrae_pkg::OFS_IRQ_STAT, 32'h7);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        $display("test interrupt done");
        apb(1'b1, mrae_pkg::OFS_CTRL, 32'h3);
        rec(1'b0, 32'h2);
        chk(hdr_n, 0);
        $display("test raw record done");
        apb(1'b1, mrae_pkg::OFS_FETCH, 32'h1);
        repeat (6) @(posedge sys_clk);
        chk(fetch_n, 1);
        $display("test fetch done");
        end_sim();
    end
endmodule : multi_record_acquisition_engine_tb
`default_nettype wire
